// [logic/sgf_buf_mem.sv]
// Byte memory for one routing buffer direction.
// Assumes write and read pointers are kept by the instantiating block.
`timescale 1ns/1ps
`default_nettype none
module sgf_buf_mem
  import sgf_pkg::*;
#(
  parameter int W = 8,
  parameter int D = BUF_DEPTH,
  parameter int AW = BUF_AW
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_q [D];

  // Storage
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= '0;
    end
    else
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule
`default_nettype wire

// [logic/sgf_led_stretch.sv]
// Stretches a one-cycle event into a visible LED pulse.
// Assumes events are already synchronous one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module sgf_led_stretch #(
  parameter int CYC = 2,
  parameter logic IDLE_LVL = 1'b0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic evt_i,
  // LED drive
  output logic led_o
);
  localparam int W = $clog2(CYC + 1);
  logic [W-1:0] cnt_q;

  // Stretch counter, restarted by each event
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      led_o <= IDLE_LVL;
    end
    else if (clr_i)
    begin
      cnt_q <= '0;
      led_o <= IDLE_LVL;
    end
    else if (evt_i)
    begin
      cnt_q <= W'(CYC - 1);
      led_o <= ~IDLE_LVL;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
    else
    begin
      led_o <= IDLE_LVL;
    end
  end

  AST_LED_EVT: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) evt_i && !clr_i |=> led_o != IDLE_LVL)
    else $error("LED did not react to event");
  AST_LED_IDLE: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) cnt_q == '0 && !evt_i |=> led_o == IDLE_LVL)
    else $error("LED not back at idle level");
endmodule
`default_nettype wire

// [logic/sgf_pkg.sv]
// Shared constants and types for the serial, GPIO and LED front end.
// Assumes a single 40 MHz clock and an AXI4-Lite register bus.
// Operation
// - Six lines; five drive and read, the input-only line never drives.
// - Lines only pull low; a weak pull-up gives high; no direction bit.
// - Writing a line high releases it so the pin level can be read.
// - A control bit turns the RTS/direction line into the RTS output.
// - Serial lines idle high; low start bit, high stop bit.
// - Low on CTS or RTS allows sending; high forbids it.
// - Activity LED normally lit, goes dark briefly on each received packet.
// - Collision LED normally dark, lights briefly on each collision.
// - Device reset pin is active high and holds the block while high.
// - On leaving reset, boot select high runs the application, low upgrades.
// - While running, boot select low requests serial programming mode.
// - One 510-byte routing buffer per direction.
// - Remapped RTS line is RTS in full duplex, direction in half duplex.
// - Remapped DTR line drives DTR; the input-only line reads DSR.
// - Rates 150 to 115200 bit/s; parity none/even/odd/mark/space; 7 or 8 bits.
package sgf_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int LED_MS = 50;
  localparam int LED_CYC = LED_MS * (CLK_HZ / 1000);
  localparam int BAUD_DEF = 115200;
  localparam logic [19:0] BAUD_DIV_RST = 20'(CLK_HZ / BAUD_DEF - 1);
  localparam int BUF_DEPTH = 510;
  localparam int BUF_AW = 9;
  localparam logic [BUF_AW-1:0] PTR_LAST = 9'(BUF_DEPTH - 1);
  localparam logic [9:0] BUF_FULL = 10'(BUF_DEPTH);
  localparam logic [9:0] RTS_LIMIT = 10'(BUF_DEPTH - 16);
  localparam logic [3:0] FRAME_FIX = 4'h2;
  localparam logic [3:0] DBITS8 = 4'h8;
  localparam logic [3:0] DBITS7 = 4'h7;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GPIO_OUT = 8'h04;
  localparam logic [7:0] A_GPIO_IN = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_BAUD = 8'h10;
  localparam logic [7:0] A_TXDATA = 8'h14;
  localparam logic [7:0] A_RXDATA = 8'h18;
  // Control fields
  localparam int C_RTS = 0;
  localparam int C_DTR = 1;
  localparam int C_HALF = 2;
  localparam int C_SELPIN = 3;
  localparam int C_DTRON = 4;
  localparam int C_EIGHT = 5;
  localparam int C_PAR = 6;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h020;
  // Line layout
  localparam int L_DSR = 2;
  localparam int L_DTR = 3;
  localparam int L_SEL = 4;
  localparam int L_RTS = 5;
  localparam logic [5:0] GPIO_RST = 6'h3f;
  localparam logic [5:0] OD_MASK = 6'h3b;
  localparam logic [10:0] SYNC_RST = 11'h7fc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_MARK,
    PAR_SPACE} sgf_par_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} sgf_tx_t;
  typedef enum logic {RX_IDLE, RX_RUN} sgf_rx_t;
endpackage

// [logic/sgf_top.sv]
// Serial port, quasi-bidirectional lines, reset, boot select and LEDs.
// Assumes an AXI4-Lite master; all pins are asynchronous to REF_CLK_I.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sgf_top
  import sgf_pkg::*;
#(
  parameter int LED_CYCLES = LED_CYC
)
(
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // AXI4-Lite write
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // General-purpose lines
  input wire logic [5:0] GPIO_I,
  output logic [5:0] GPIO_O,
  output logic [5:0] GPIO_OE_O,
  // Serial port
  output logic SER_TX_O,
  input wire logic SER_RX_I,
  // Reset and mode pins
  input wire logic DEV_RST_I,
  input wire logic BOOT_SELECT_PIN_I,
  // Ethernet status
  input wire logic ETH_RX_PKT_I,
  input wire logic ETH_COLL_I,
  output logic ETH_ACTIVITY_LED_O,
  output logic ETH_COLLISION_LED_O
);
  logic [10:0] s1_q, s2_q;
  logic [1:0] ev_q;
  logic hold_q, boot_app_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [5:0] gpio_q, lv;
  logic [19:0] baud_q;
  logic awready_q, wready_q, aw_q, w_q, bvalid_q;
  logic arready_q, rd_pend_q, rvalid_q;
  logic [7:0] aw_addr_q, ar_addr_q;
  logic [31:0] wdata_q, rd_mux;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [BUF_AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [9:0] tx_cnt_q, rx_cnt_q;
  logic [7:0] tx_rd, rx_rd, rx_d_q;
  sgf_tx_t tx_st;
  sgf_rx_t rx_st;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_bits_q, rx_idx_q, nbits, dbits;
  logic [19:0] tx_tm_q, rx_tm_q;
  logic tx_q;
  logic [5:0] gpio_s;
  logic rx_s, hold, boot_s, half, cts_s, eight, rts_val;
  logic wr_go, wr_hit, rd_hit, tx_push, tx_pop, rx_push, rx_pop;
  logic pkt_pulse, coll_pulse, prog_req;
  logic [2:0] pmode;

  // Input synchronisers
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      ev_q <= '0;
      hold_q <= 1'b1;
    end
    else
    begin
      s1_q <= {GPIO_I, SER_RX_I, DEV_RST_I, BOOT_SELECT_PIN_I,
        ETH_RX_PKT_I, ETH_COLL_I};
      s2_q <= s1_q;
      ev_q <= s2_q[1:0];
      hold_q <= s2_q[3];
    end
  end

  assign gpio_s = s2_q[10:5];
  assign rx_s = s2_q[4];
  assign hold = s2_q[3];
  assign boot_s = s2_q[2];
  assign pkt_pulse = s2_q[1] & ~ev_q[1];
  assign coll_pulse = s2_q[0] & ~ev_q[0];
  assign cts_s = gpio_s[L_SEL];
  assign eight = ctrl_q[C_EIGHT];
  assign pmode = ctrl_q[C_PAR +: 3];
  assign half = ctrl_q[C_SELPIN] ? cts_s : ctrl_q[C_HALF];
  assign prog_req = boot_app_q & ~boot_s;

  // Boot mode caught on release of device reset
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      boot_app_q <= 1'b0;
    end
    else if (hold_q && !hold)
    begin
      boot_app_q <= boot_s;
    end
  end

  // Frame shape
  assign dbits = eight ? DBITS8 : DBITS7;
  assign nbits = FRAME_FIX + dbits + 4'(pmode != PAR_NONE);

  function automatic logic par_f(input logic [7:0] d, input logic e,
    input logic [2:0] m);
    logic x;
    x = ^(e ? d : {1'b0, d[6:0]});
    unique case (m)
      PAR_EVEN: par_f = x;
      PAR_ODD: par_f = ~x;
      PAR_SPACE: par_f = 1'b0;
      default: par_f = 1'b1;
    endcase
  endfunction

  function automatic logic [10:0] frame_f(input logic [7:0] d,
    input logic e, input logic [2:0] m);
    logic p;
    p = (m == PAR_NONE) ? 1'b1 : par_f(d, e, m);
    frame_f = e ? {2'b11, p, d} : {3'b111, p, d[6:0]};
  endfunction

  function automatic logic [31:0] mrg_f(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    mrg_f = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        mrg_f[8*i +: 8] = n[8*i +: 8];
      end
    end
  endfunction

  function automatic logic [BUF_AW-1:0] nxt_f(input logic [BUF_AW-1:0] p);
    nxt_f = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  // AXI write channel handshakes
  assign wr_go = aw_q & w_q & ~bvalid_q;
  assign wr_hit = aw_addr_q inside {A_CTRL, A_GPIO_OUT, A_GPIO_IN,
    A_STATUS, A_BAUD, A_TXDATA, A_RXDATA};
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID_I && awready_q)
      begin
        aw_addr_q <= S_AXI_AWADDR_I;
        awready_q <= 1'b0;
        aw_q <= 1'b1;
      end
      if (S_AXI_WVALID_I && wready_q)
      begin
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
        wready_q <= 1'b0;
        w_q <= 1'b1;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (bvalid_q && S_AXI_BREADY_I)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Software registers
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl_q <= CTRL_RST;
      gpio_q <= GPIO_RST;
      baud_q <= BAUD_DIV_RST;
    end
    else if (hold)
    begin
      ctrl_q <= CTRL_RST;
      gpio_q <= GPIO_RST;
      baud_q <= BAUD_DIV_RST;
    end
    else if (wr_go)
    begin
      if (aw_addr_q == A_CTRL)
        ctrl_q <= CTRL_W'(mrg_f(32'(ctrl_q), wdata_q, wstrb_q));
      if (aw_addr_q == A_GPIO_OUT)
        gpio_q <= 6'(mrg_f(32'(gpio_q), wdata_q, wstrb_q));
      if (aw_addr_q == A_BAUD)
        baud_q <= 20'(mrg_f(32'(baud_q), wdata_q, wstrb_q));
    end
  end

  // AXI read channel
  assign rd_hit = ar_addr_q inside {A_CTRL, A_GPIO_OUT, A_GPIO_IN,
    A_STATUS, A_BAUD, A_TXDATA, A_RXDATA};
  assign rx_pop = rd_pend_q & (ar_addr_q == A_RXDATA) & (rx_cnt_q != '0)
    & ~hold;
  always_comb
  begin
    rd_mux = '0;
    unique case (ar_addr_q)
      A_CTRL: rd_mux = 32'(ctrl_q);
      A_GPIO_OUT: rd_mux = 32'(gpio_q);
      A_GPIO_IN: rd_mux = 32'(gpio_s);
      A_STATUS: rd_mux = 32'({hold, tx_st != TX_IDLE, rx_cnt_q != '0,
        tx_cnt_q == BUF_FULL, ~gpio_s[L_DSR], ~cts_s, prog_req,
        boot_app_q});
      A_BAUD: rd_mux = 32'(baud_q);
      A_RXDATA: rd_mux = 32'({rx_pop, rx_rd});
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      arready_q <= 1'b1;
      rd_pend_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      ar_addr_q <= '0;
    end
    else
    begin
      if (S_AXI_ARVALID_I && arready_q)
      begin
        ar_addr_q <= S_AXI_ARADDR_I;
        arready_q <= 1'b0;
        rd_pend_q <= 1'b1;
      end
      if (rd_pend_q)
      begin
        rd_pend_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (rvalid_q && S_AXI_RREADY_I)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Routing buffers, one per direction
  assign tx_push = wr_go & (aw_addr_q == A_TXDATA) & wstrb_q[0]
    & (tx_cnt_q != BUF_FULL) & ~hold;
  assign tx_pop = (tx_st == TX_IDLE) & (tx_cnt_q != '0) & ~hold
    & (half | ~ctrl_q[C_RTS] | ~cts_s);

  sgf_buf_mem #(.W(8), .D(BUF_DEPTH), .AW(BUF_AW)) u_net2ser (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(tx_push),
    .waddr_i(tx_wp_q),
    .wdata_i(wdata_q[7:0]),
    .raddr_i(tx_rp_q),
    .rdata_o(tx_rd)
  );
  sgf_buf_mem #(.W(8), .D(BUF_DEPTH), .AW(BUF_AW)) u_ser2net (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(rx_push),
    .waddr_i(rx_wp_q),
    .wdata_i(eight ? rx_d_q : {1'b0, rx_d_q[6:0]}),
    .raddr_i(rx_rp_q),
    .rdata_o(rx_rd)
  );

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end
    else if (hold)
    begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0;
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp_q <= nxt_f(tx_wp_q);
      if (tx_pop)
        tx_rp_q <= nxt_f(tx_rp_q);
      tx_cnt_q <= tx_cnt_q + 10'(tx_push) - 10'(tx_pop);
      if (rx_push)
        rx_wp_q <= nxt_f(rx_wp_q);
      if (rx_pop)
        rx_rp_q <= nxt_f(rx_rp_q);
      rx_cnt_q <= rx_cnt_q + 10'(rx_push) - 10'(rx_pop);
    end
  end

  // Transmitter
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      tx_st <= TX_IDLE;
      tx_q <= 1'b1;
      tx_sh_q <= '1;
      tx_bits_q <= '0;
      tx_tm_q <= '0;
    end
    else if (hold)
    begin
      tx_st <= TX_IDLE;
      tx_q <= 1'b1;
    end
    else
    begin
      unique case (tx_st)
        TX_IDLE:
        begin
          tx_q <= 1'b1;
          if (tx_pop)
            tx_st <= TX_LOAD;
        end
        TX_LOAD:
        begin
          tx_sh_q <= {1'b1, frame_f(tx_rd, eight, pmode)} << 1;
          tx_bits_q <= nbits;
          tx_tm_q <= baud_q;
          tx_st <= TX_SEND;
        end
        TX_SEND:
        begin
          tx_q <= tx_sh_q[0];
          if (tx_tm_q == '0)
          begin
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            tx_tm_q <= baud_q;
            tx_bits_q <= tx_bits_q - 1'b1;
            if (tx_bits_q == 4'h1)
              tx_st <= TX_IDLE;
          end
          else
            tx_tm_q <= tx_tm_q - 1'b1;
        end
      endcase
    end
  end

  // Receiver, samples each bit at its middle
  assign rx_push = (rx_st == RX_RUN) & (rx_tm_q == '0) & rx_s & ~hold
    & (rx_idx_q == nbits - 1'b1) & (rx_cnt_q != BUF_FULL);
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rx_st <= RX_IDLE;
      rx_tm_q <= '0;
      rx_idx_q <= '0;
      rx_d_q <= '0;
    end
    else if (hold)
    begin
      rx_st <= RX_IDLE;
    end
    else
    begin
      unique case (rx_st)
        RX_IDLE:
        begin
          if (!rx_s)
          begin
            rx_st <= RX_RUN;
            rx_tm_q <= baud_q >> 1;
            rx_idx_q <= '0;
          end
        end
        RX_RUN:
        begin
          if (rx_tm_q == '0)
          begin
            rx_tm_q <= baud_q;
            rx_idx_q <= rx_idx_q + 1'b1;
            if ((rx_idx_q == '0 && rx_s) || rx_idx_q == nbits - 1'b1)
              rx_st <= RX_IDLE;
            else if (rx_idx_q != '0 && rx_idx_q <= dbits)
              rx_d_q[3'(rx_idx_q - 1'b1)] <= rx_s;
          end
          else
            rx_tm_q <= rx_tm_q - 1'b1;
        end
      endcase
    end
  end

  // Line drive: only ever pulls low
  assign rts_val = half ? (tx_st != TX_IDLE)
    : (rx_cnt_q >= RTS_LIMIT);
  always_comb
  begin
    lv = gpio_q;
    if (ctrl_q[C_RTS])
      lv[L_RTS] = rts_val;
    if (ctrl_q[C_DTR])
      lv[L_DTR] = ~ctrl_q[C_DTRON];
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      GPIO_O <= '0;
      GPIO_OE_O <= '0;
    end
    else
    begin
      GPIO_O <= '0;
      GPIO_OE_O <= ~lv & OD_MASK;
    end
  end

  assign SER_TX_O = tx_q;
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O = wready_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;

  // Ethernet LEDs
  sgf_led_stretch #(.CYC(LED_CYCLES), .IDLE_LVL(1'b1)) u_act_led (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(hold),
    .evt_i(pkt_pulse),
    .led_o(ETH_ACTIVITY_LED_O)
  );
  sgf_led_stretch #(.CYC(LED_CYCLES), .IDLE_LVL(1'b0)) u_coll_led (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(hold),
    .evt_i(coll_pulse),
    .led_o(ETH_COLLISION_LED_O)
  );

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  AST_INPUT_ONLY: assert property (!GPIO_OE_O[L_DSR])
    else $error("Input-only line driven");
  AST_LOW_ONLY: assert property (GPIO_O == '0)
    else $error("Line driven high");
  AST_RELEASED: assert property (gpio_q[0] |=> !GPIO_OE_O[0])
    else $error("Line high but still pulled low");
  AST_RTS_STOP: assert property (ctrl_q[C_RTS] && !half && !hold
    && rx_cnt_q >= RTS_LIMIT |=> !GPIO_OE_O[L_RTS])
    else $error("RTS not high with buffer near full");
  AST_START_LOW: assert property (
    (tx_st == TX_LOAD && !hold) ##1 !hold |=> !SER_TX_O)
    else $error("Start bit not low");
  AST_IDLE_HIGH: assert property (tx_st == TX_IDLE
    && $past(tx_st) == TX_IDLE |-> SER_TX_O)
    else $error("Idle transmit line not high");
  AST_CTS_GATE: assert property ($rose(tx_st == TX_LOAD)
    && ctrl_q[C_RTS] && !half |-> !$past(cts_s))
    else $error("Sent while CTS high");
  AST_HOLD: assert property (hold |=> tx_st == TX_IDLE
    && tx_cnt_q == '0 && rx_cnt_q == '0)
    else $error("Block not held by device reset");
  AST_BOOT: assert property ($fell(hold)
    |=> boot_app_q == $past(boot_s))
    else $error("Boot select not captured");
  AST_DEPTH: assert property (tx_cnt_q <= BUF_FULL
    && rx_cnt_q <= BUF_FULL)
    else $error("Buffer count past depth");
  AST_DTR: assert property (ctrl_q[C_DTR] && ctrl_q[C_DTRON]
    |=> GPIO_OE_O[L_DTR])
    else $error("DTR not asserted low");
endmodule
`default_nettype wire

// [tb/sgf_top_tb.sv]
// Self-checking bench for the serial, GPIO and LED front end.
// Assumes the host serial model and a 40 MHz reference clock.
`timescale 1ns/1ps
`default_nettype none
module sgf_top_tb
  import sgf_pkg::*;
;
  logic clk = 1'b0, rn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, drst = 1'b1, boot = 1'b1;
  logic pkt = 1'b0, col = 1'b0, ok;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, dat;
  logic [5:0] ext = 6'h3f, go, oe;
  logic awr, wrr, bv, arr, rv, tx, rx, la, lc;
  logic [1:0] br, rr, resp;
  logic [9:0] f;
  int mismatches = 0, cmp_count = 0;
  wire logic [5:0] pin;
  assign pin = ~oe & ext;  // Pull-up unless pulled low
  always #12.5 clk = ~clk;
  sgf_top #(.LED_CYCLES(8)) u_dut (
    .REF_CLK_I(clk), .RST_N_I(rn), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rry), .GPIO_I(pin), .GPIO_O(go), .GPIO_OE_O(oe),
    .SER_TX_O(tx), .SER_RX_I(rx), .DEV_RST_I(drst),
    .BOOT_SELECT_PIN_I(boot), .ETH_RX_PKT_I(pkt), .ETH_COLL_I(col),
    .ETH_ACTIVITY_LED_O(la), .ETH_COLLISION_LED_O(lc));
  sgf_uart_host u_host (.clk_i(clk), .tx_i(tx), .rx_o(rx));
  task automatic test_done();
    $display("mismatches=%0d compares=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tmo();
    mismatches++;
    test_done();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wrr)
        wv <= 1'b0;
      if (bv)
      begin
        resp = br;
        bry <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'b0;
      if (rv)
      begin
        dat = rdat;
        resp = rr;
        rry <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    rd(a);
    chk(dat & m, e);
  endtask
  task automatic t_reset();
    chk(32'(tx), 32'h1);
    chk(32'(oe), 32'h0);
    chk(32'({la, lc}), 32'h2);
    rdc(A_GPIO_OUT, 32'h3f, 32'h3f);
    rdc(A_CTRL, 32'h1ff, 32'h20);
  endtask
  task automatic t_boot();
    drst <= 1'b1;
    cyc(4);
    rdc(A_STATUS, 32'h80, 32'h80);
    drst <= 1'b0;
    cyc(6);
    rdc(A_STATUS, 32'h81, 32'h1);
    boot <= 1'b0;
    cyc(4);
    rdc(A_STATUS, 32'h3, 32'h3);
    drst <= 1'b1;
    cyc(4);
    drst <= 1'b0;
    cyc(6);
    rdc(A_STATUS, 32'h1, 32'h0);
  endtask
  task automatic t_gpio();
    wr(A_GPIO_OUT, 32'h0);
    cyc(4);
    chk(32'(oe), 32'h3b);
    chk(32'(go), 32'h0);
    rdc(A_GPIO_IN, 32'h3f, 32'h4);
    wr(A_GPIO_OUT, 32'h3f);
    ext <= 6'h3e;
    cyc(4);
    chk(32'(oe), 32'h0);
    rdc(A_GPIO_IN, 32'h3f, 32'h3e);
    ext <= 6'h3f;
  endtask
  task automatic evt();
    pkt <= 1'b1;
    col <= 1'b1;
    cyc(3);
    pkt <= 1'b0;
    col <= 1'b0;
  endtask
  task automatic t_led();
    evt();
    cyc(3);
    chk(32'({la, lc}), 32'h1);
    evt();
    cyc(5);
    chk(32'({la, lc}), 32'h1);
    cyc(20);
    chk(32'({la, lc}), 32'h2);
  endtask
  task automatic t_tx();
    wr(A_BAUD, 32'h3);
    fork
      wr(A_TXDATA, 32'ha5);
      u_host.recv(f, ok);
    join
    chk(32'({ok, f}), 32'h74a);
  endtask
  task automatic t_rts();
    wr(A_CTRL, 32'h33);
    cyc(3);
    chk(32'(oe & 6'h38), 32'h28);
    wr(A_TXDATA, 32'h5a);
    cyc(30);
    chk(32'(tx), 32'h1);
    ext <= 6'h2f;
    u_host.recv(f, ok);
    chk(32'({ok, f}), 32'h6b4);
  endtask
  task automatic t_rx();
    u_host.send(8'h3c);
    cyc(8);
    rdc(A_RXDATA, 32'h1ff, 32'h13c);
    rdc(A_RXDATA, 32'h100, 32'h0);
    for (int i = 0; i < int'(RTS_LIMIT); i++)
      u_host.send(8'(i));
    cyc(8);
    chk(32'(oe[L_RTS]), 32'h0);
    rdc(A_RXDATA, 32'h1ff, 32'h100);
    rdc(A_RXDATA, 32'h1ff, 32'h101);
    cyc(2);
    chk(32'(oe[L_RTS]), 32'h1);
  endtask
  task automatic t_par();
    wr(A_CTRL, 32'h85);
    fork
      begin
        wr(A_TXDATA, 32'h5a);
        cyc(12);
        chk(32'(oe[L_RTS]), 32'h0);
      end
      u_host.recv(f, ok);
    join
    chk(32'({ok, f}), 32'h7b4);
    chk(32'(oe[L_RTS]), 32'h1);
  endtask
  task automatic t_err();
    wr(8'h40, 32'h1);
    chk(32'(resp), 32'h3);
    rd(8'h40);
    chk({dat[29:0], resp}, 32'h3);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);  // Reset held at power-up
    rn <= 1'b1;
    cyc(2);
    drst <= 1'b0;  // Host releases the held device reset
    cyc(8);
    t_reset();
    t_boot();
    t_gpio();
    t_led();
    t_tx();
    t_rts();
    t_rx();
    t_par();
    t_err();
    test_done();
  end
endmodule
`default_nettype wire

// [tb/sgf_uart_host.sv]
// Host-side serial model: drives the receive line, captures frames.
// Assumes ten-bit frames and a bit time of bt clocks.
`timescale 1ns/1ps
`default_nettype none
module sgf_uart_host (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic tx_i,
  output logic rx_o
);
  int bt = 4;
  initial rx_o = 1'b1;  // Idle high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};  // Start, LSB first, stop
    for (int i = 0; i < 10; i++)
    begin
      rx_o <= f[i];
      repeat (bt) @(posedge clk_i);
    end
  endtask
  task automatic recv(output logic [9:0] f, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++)
    begin
      @(posedge clk_i);
      #1 ok = !tx_i;
    end
    repeat (bt / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      #1 f[i] = tx_i;
      repeat (bt) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire
